//--- zcd_top.sv
// Zero-cross detector digital side: control register, edge interrupts, AXI4-Lite slave.
// Assumes the analog clamp supplies sink_active and software keeps the pin pull-up off.
//
// Overview of operation
// - Analog clamp sinks above reference, sources below; input is that decision.
// - Level flag reads one while sinking when inversion is clear.
// - Invert select flips the level flag and the edge detection source.
// - Polarity-adjusted level is routed out to other peripherals.
// - Separate rising and falling detectors act on the adjusted level.
// - Flag sets on an enabled rising or falling edge, or on a control write that changes invert select.
// - Writing a changed invert select itself produces a crossing event.
// - An edge in the clearing cycle wins; flag stays set.
// - Fuse clear means always enabled; fuse set follows software enable.
// - Control word at index 0x101f holds enable, level, invert, edge enables.
// - Detector and interrupts keep running during processor sleep.
// - Module disable bit turns detector off, only when the fuse allows.
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
module zcd_top
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Analog side
    input  wire logic        sink_active,
    input  wire logic        config_fuse,
    input  wire logic        cpu_sleep,
    output logic             clamp_enable,
    // Peripheral routing and interrupt
    output logic             crossing_level,
    output logic             irq,
    // AXI4-Lite write address
    input  wire logic [15:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [15:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    import zcd_pkg::*;

    zcd_ctrl_t   ctrl;
    logic        crossing_irq_flag;
    logic        crossing_irq_enable;
    logic        global_irq_enable;
    logic        low_priority_irq_enable;
    logic        crossing_module_disable;
    logic        aw_held;
    logic        w_held;
    logic [15:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        level;
    logic        rise_pulse;
    logic        fall_pulse;

    // Enable: fuse clear forces the detector on regardless of other bits
    wire det_run = ~config_fuse | (ctrl.sw_enable & ~crossing_module_disable);

    // Sleep is deliberately not an input to any term below
    wire run_in_sleep = det_run;

    zcd_edge u_edge
    (
        .mclk          (mclk),
        .rst           (rst),
        .sink_active   (sink_active),
        .invert_select (ctrl.invert_select),
        .run           (run_in_sleep),
        .level         (level),
        .rise_pulse    (rise_pulse),
        .fall_pulse    (fall_pulse)
    );

    // Write channel decode
    wire        aw_ok    = aw_held | s_axi_awvalid;
    wire        w_ok     = w_held | s_axi_wvalid;
    wire        wr_fire  = aw_ok & w_ok & ~s_axi_bvalid;
    wire [15:0] wr_addr  = aw_held ? aw_addr : s_axi_awaddr;
    wire [31:0] wr_data  = w_held ? w_data : s_axi_wdata;
    wire [3:0]  wr_strb  = w_held ? w_strb : s_axi_wstrb;
    wire        wr_lane0 = wr_fire & wr_strb[0];
    wire        wr_ctrl  = wr_lane0 & (wr_addr == ZCD_CONTROL_OFS);
    wire        wr_ien   = wr_lane0 & (wr_addr == ZCD_IRQ_ENABLE_OFS);
    wire        wr_clr   = wr_lane0 & (wr_addr == ZCD_IRQ_CLEAR_OFS);
    wire        wr_sys   = wr_lane0 & (wr_addr == ZCD_SYSCTL_OFS);
    wire        wr_known = (wr_addr == ZCD_CONTROL_OFS) | (wr_addr == ZCD_IRQ_STATUS_OFS)
                         | (wr_addr == ZCD_IRQ_ENABLE_OFS) | (wr_addr == ZCD_IRQ_CLEAR_OFS)
                         | (wr_addr == ZCD_SYSCTL_OFS);

    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;

    // Crossing event: enabled edge, or a control write that changes inversion
    wire edge_event = (rise_pulse & ctrl.rise_irq_enable)
                    | (fall_pulse & ctrl.fall_irq_enable);
    wire pol_event  = wr_ctrl & (wr_data[ZCD_INVERT_BIT] != ctrl.invert_select);
    wire clr_flag   = wr_clr & wr_data[ZCD_CROSS_BIT];
    wire next_flag  = edge_event | pol_event | (crossing_irq_flag & ~clr_flag);

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 16'h0000;
            w_data  <= 32'h00000000;
            w_strb  <= 4'h0;
        end
        else
        begin
            if (wr_fire)
                aw_held <= 1'b0;
            else if (s_axi_awvalid & s_axi_awready)
                aw_held <= 1'b1;
            if (wr_fire)
                w_held <= 1'b0;
            else if (s_axi_wvalid & s_axi_wready)
                w_held <= 1'b1;
            if (s_axi_awvalid & s_axi_awready)
                aw_addr <= s_axi_awaddr;
            if (s_axi_wvalid & s_axi_wready)
            begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    // Write response
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= ZCD_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? ZCD_RESP_OKAY : ZCD_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Control register; level bit is read-only and not stored
    always_ff @(posedge mclk)
    begin
        if (rst)
            ctrl <= zcd_ctrl_t'(4'h0);
        else if (wr_ctrl)
        begin
            ctrl.sw_enable       <= wr_data[ZCD_SW_EN_BIT];
            ctrl.invert_select   <= wr_data[ZCD_INVERT_BIT];
            ctrl.rise_irq_enable <= wr_data[ZCD_RISE_EN_BIT];
            ctrl.fall_irq_enable <= wr_data[ZCD_FALL_EN_BIT];
        end
    end

    // Interrupt flag and enables
    always_ff @(posedge mclk)
    begin
        if (rst)
            crossing_irq_flag <= 1'b0;
        else
            crossing_irq_flag <= next_flag;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            crossing_irq_enable <= 1'b0;
        else if (wr_ien)
            crossing_irq_enable <= wr_data[ZCD_CROSS_BIT];
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            {crossing_module_disable, low_priority_irq_enable, global_irq_enable}
                <= ZCD_SYSCTL_RST;
        else if (wr_sys)
            {crossing_module_disable, low_priority_irq_enable, global_irq_enable}
                <= wr_data[ZCD_PMD_BIT:ZCD_GIE_BIT];
    end

    // Processor interrupt needs every enable in the chain
    assign irq = crossing_irq_flag & crossing_irq_enable
               & global_irq_enable & low_priority_irq_enable;

    assign crossing_level = level;
    assign clamp_enable   = det_run;

    // Read path
    wire [7:0] ctrl_rd = {ctrl.sw_enable, 1'b0, level, ctrl.invert_select,
                          2'b00, ctrl.rise_irq_enable, ctrl.fall_irq_enable};
    wire       rd_hit_ctrl = (s_axi_araddr == ZCD_CONTROL_OFS);
    wire       rd_hit_stat = (s_axi_araddr == ZCD_IRQ_STATUS_OFS);
    wire       rd_hit_ien  = (s_axi_araddr == ZCD_IRQ_ENABLE_OFS);
    wire       rd_hit_clr  = (s_axi_araddr == ZCD_IRQ_CLEAR_OFS);
    wire       rd_hit_sys  = (s_axi_araddr == ZCD_SYSCTL_OFS);
    wire       rd_known    = rd_hit_ctrl | rd_hit_stat | rd_hit_ien | rd_hit_clr | rd_hit_sys;
    wire [31:0] rd_word    = rd_hit_ctrl ? {24'h000000, ctrl_rd}
                           : rd_hit_stat ? {31'h00000000, crossing_irq_flag}
                           : rd_hit_ien  ? {31'h00000000, crossing_irq_enable}
                           : rd_hit_sys  ? {29'h00000000, crossing_module_disable,
                                            low_priority_irq_enable, global_irq_enable}
                           : 32'h00000000;

    assign s_axi_arready = ~s_axi_rvalid;

    // Reads never touch the flag
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= ZCD_RESP_OKAY;
        end
        else if (s_axi_arvalid & s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_known ? ZCD_RESP_OKAY : ZCD_RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // cpu_sleep is accepted for completeness and intentionally unused
    wire unused_sleep = cpu_sleep;

endmodule : zcd_top

//--- zcd_pkg.sv
// Package for the zero-cross detector logic: register map, field positions, reset values.
// Assumes a 32-bit AXI4-Lite register bus and one clock, mclk.
package zcd_pkg;

    // Register byte addresses, plus the control word index
    localparam logic [15:0] ZCD_CONTROL_OFS    = 16'h101c;  // control word, index 0x101f
    localparam logic [15:0] ZCD_CONTROL_IDX    = 16'h101f;
    localparam logic [15:0] ZCD_IRQ_STATUS_OFS = 16'h1100;
    localparam logic [15:0] ZCD_IRQ_ENABLE_OFS = 16'h1104;
    localparam logic [15:0] ZCD_IRQ_CLEAR_OFS  = 16'h1108;
    localparam logic [15:0] ZCD_SYSCTL_OFS     = 16'h110c;

    // Control field positions
    localparam int ZCD_SW_EN_BIT   = 7;
    localparam int ZCD_LEVEL_BIT   = 5;
    localparam int ZCD_INVERT_BIT  = 4;
    localparam int ZCD_RISE_EN_BIT = 1;
    localparam int ZCD_FALL_EN_BIT = 0;

    // Status / enable / clear layout
    localparam int ZCD_CROSS_BIT = 0;

    // System control layout
    localparam int ZCD_GIE_BIT   = 0;
    localparam int ZCD_LOW_PRIORITY_IRQ_ENABLE_BIT  = 1;
    localparam int ZCD_PMD_BIT   = 2;

    // Reset values
    localparam logic [7:0] ZCD_CONTROL_RST = 8'h00;
    localparam logic [2:0] ZCD_SYSCTL_RST  = 3'h0;

    // AXI responses
    localparam logic [1:0] ZCD_RESP_OKAY   = 2'h0;
    localparam logic [1:0] ZCD_RESP_SLVERR = 2'h2;

    // Control fields carried between files
    typedef struct packed {
        logic sw_enable;
        logic invert_select;
        logic rise_irq_enable;
        logic fall_irq_enable;
    } zcd_ctrl_t;

endpackage : zcd_pkg

//--- zcd_edge.sv
// Synchroniser, polarity and edge detection for the comparator decision.
// Assumes sink_active is asynchronous; reset primes history from the pin.
module zcd_edge
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // Comparator decision and control
    input  wire logic sink_active,
    input  wire logic invert_select,
    input  wire logic run,
    // Results
    output logic      level,
    output logic      rise_pulse,
    output logic      fall_pulse
);
    import zcd_pkg::*;

    logic sync_a;
    logic sync_b;
    logic history;
    wire  adj_now = sync_b ^ invert_select;

    // Reset loads live decision through the chain so release creates no edge
    always_ff @(posedge mclk)
    begin
        sync_a  <= sink_active;
        sync_b  <= sync_a;
        if (rst)
            history <= sync_b ^ invert_select;
        else
            history <= adj_now;
    end

    // Inversion change toggles adj_now, so a polarity write yields an edge pulse
    assign level      = adj_now;
    assign rise_pulse = run & ~rst & adj_now & ~history;
    assign fall_pulse = run & ~rst & ~adj_now & history;

endmodule : zcd_edge

//--- zcd_props.sv
// Checker for the zero-cross detector top: bus answers, pin path, interrupt line.
// Bound to zcd_top; sees its ports only, one mclk domain.
module zcd_props
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Pin side
    input wire logic sink_active,
    input wire logic config_fuse,
    input wire logic clamp_enable,
    input wire logic crossing_level,
    input wire logic irq,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("write answer late");
    chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
    chk_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data held too long");
    // Fuse clear keeps the clamp on whatever software wrote
    chk_fuse_on: assert property (!config_fuse |-> clamp_enable)
        else $error("clamp off with fuse clear");
    // A bus write may flip the level, so only quiet cycles are judged
    chk_level_delay: assert property (!s_axi_bvalid |-> $changed(crossing_level) ==
        ($past(sink_active, 2) != $past(sink_active, 3))) else $error("level path delay");
    chk_irq_sticky: assert property ($fell(irq) |-> s_axi_bvalid)
        else $error("irq dropped without a write");

    cov_irq: cover property ($rose(irq));
    cov_fuse_on: cover property (config_fuse && clamp_enable);
    cov_level: cover property ($changed(crossing_level));
endmodule : zcd_props

bind zcd_top zcd_props zcd_props_i (.*);

//--- zcd_src_model.sv
// AC source behind its series resistor, seen as the clamp's sink/source decision.
// Assumes the bench sets above_ref; the decision settles well inside one cycle.
module zcd_src_model
#(
    parameter int SETTLE_NS = 30
)
(
    // Source level against the crossing reference
    input  wire logic above_ref,
    // Clamp decision
    output logic      sink_active
);
    timeunit 1ns;
    timeprecision 1ns;
    // Sinks above the reference, sources below; no weak pull-up on the pin
    assign #(SETTLE_NS) sink_active = above_ref;
endmodule : zcd_src_model

//--- testbench.sv
// Self-checking bench for zcd_top over its AXI4-Lite port and source model.
// Assumes the package map; one write or read at a time.
module testbench;
    import zcd_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic mclk = 0, rst = 1, above_ref = 1, config_fuse = 0, cpu_sleep = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic sink_active, clamp_enable, crossing_level, irq;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int miscompares = 0, checks_done = 0;

    zcd_top zcd_top_i (.*);
    zcd_src_model zcd_src_model_i (.above_ref(above_ref), .sink_active(sink_active));

    initial forever #50 mclk = ~mclk;

    task end_of_test;
        if (miscompares == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One bus transfer; an edge passes first so no strobe is driven twice at once
    task xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        logic ah, wh, arh, done;
        n = 0;
        done = 0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        while (!done)
        begin
            @(posedge mclk);
            ah = s_axi_awvalid & s_axi_awready;
            wh = s_axi_wvalid & s_axi_wready;
            arh = s_axi_arvalid & s_axi_arready;
            done = (s_axi_bready & s_axi_bvalid) | (s_axi_rready & s_axi_rvalid);
            resp = w ? s_axi_bresp : s_axi_rresp;
            rd = s_axi_rdata;
            if (ah) s_axi_awvalid <= 1'h0;
            if (wh) s_axi_wvalid <= 1'h0;
            if (arh) s_axi_arvalid <= 1'h0;
            if (done) s_axi_bready <= 1'h0;
            if (done) s_axi_rready <= 1'h0;
            n++;
            if (n > 40)
            begin
                miscompares++;
                $display("ERROR %0t: no bus answer", $time);
                end_of_test;
            end
        end
    endtask : xfer

    task rchk(input logic [15:0] a, input logic [31:0] e);
        xfer(1'h0, a, 32'h0);
        check(rd, e);
    endtask : rchk

    // Source step; the decision needs two flops plus one edge to reach the flag
    task pin(input logic v);
        above_ref <= v;
        repeat (4) @(posedge mclk);
    endtask : pin

    initial
    begin
        repeat (16) @(posedge mclk);
        rst <= 1'h0;
        rchk(ZCD_CONTROL_OFS, 32'h20);
        check(32'(crossing_level), 32'h1);
        rchk(ZCD_IRQ_STATUS_OFS, 32'h0);
        rchk(ZCD_IRQ_CLEAR_OFS, 32'h0);
        rchk(ZCD_SYSCTL_OFS, 32'h0);
        xfer(1'h0, 16'h0010, 32'h0);
        check(32'(resp), 32'(ZCD_RESP_SLVERR));
        check(32'(clamp_enable), 32'h1);
        xfer(1'h1, ZCD_IRQ_ENABLE_OFS, 32'h1);
        check(32'(resp), 32'(ZCD_RESP_OKAY));
        xfer(1'h1, ZCD_SYSCTL_OFS, 32'h3);
        xfer(1'h1, ZCD_CONTROL_OFS, 32'h02);
        pin(1'h0);
        rchk(ZCD_IRQ_STATUS_OFS, 32'h0);
        pin(1'h1);
        rchk(ZCD_IRQ_STATUS_OFS, 32'h1);
        check(32'(irq), 32'h1);
        rchk(ZCD_IRQ_STATUS_OFS, 32'h1);
        xfer(1'h1, ZCD_SYSCTL_OFS, 32'h1);
        check(32'(irq), 32'h0);
        xfer(1'h1, ZCD_SYSCTL_OFS, 32'h3);
        xfer(1'h1, ZCD_IRQ_CLEAR_OFS, 32'h1);
        rchk(ZCD_IRQ_STATUS_OFS, 32'h0);
        cpu_sleep <= 1'h1;
        xfer(1'h1, ZCD_CONTROL_OFS, 32'h01);
        pin(1'h0);
        rchk(ZCD_IRQ_STATUS_OFS, 32'h1);
        xfer(1'h1, ZCD_IRQ_CLEAR_OFS, 32'h1);
        xfer(1'h1, ZCD_CONTROL_OFS, 32'h10);
        rchk(ZCD_IRQ_STATUS_OFS, 32'h1);
        rchk(ZCD_CONTROL_OFS, 32'h30);
        xfer(1'h1, ZCD_IRQ_CLEAR_OFS, 32'h1);
        xfer(1'h1, ZCD_CONTROL_OFS, 32'h12);
        rchk(ZCD_IRQ_STATUS_OFS, 32'h0);
        pin(1'h1);
        rchk(ZCD_IRQ_STATUS_OFS, 32'h0);
        pin(1'h0);
        rchk(ZCD_IRQ_STATUS_OFS, 32'h1);
        // Clear once the rising edge of the inverted level has set the flag, then a clear on the edge where the next falling edge sets it
        xfer(1'h1, ZCD_IRQ_CLEAR_OFS, 32'h1);
        rchk(ZCD_IRQ_STATUS_OFS, 32'h0);
        xfer(1'h1, ZCD_CONTROL_OFS, 32'h13);
        above_ref <= 1'h1;
        @(posedge mclk);
        xfer(1'h1, ZCD_IRQ_CLEAR_OFS, 32'h1);
        rchk(ZCD_IRQ_STATUS_OFS, 32'h1);
        xfer(1'h1, 16'h0010, 32'h1);
        check(32'(resp), 32'(ZCD_RESP_SLVERR));
        config_fuse <= 1'h1;
        xfer(1'h1, ZCD_CONTROL_OFS, 32'h03);
        check(32'(clamp_enable), 32'h0);
        xfer(1'h1, ZCD_CONTROL_OFS, 32'h83);
        check(32'(clamp_enable), 32'h1);
        xfer(1'h1, ZCD_SYSCTL_OFS, 32'h7);
        check(32'(clamp_enable), 32'h0);
        xfer(1'h1, ZCD_IRQ_CLEAR_OFS, 32'h1);
        pin(1'h0);
        rchk(ZCD_IRQ_STATUS_OFS, 32'h0);
        config_fuse <= 1'h0;
        @(posedge mclk);
        check(32'(clamp_enable), 32'h1);
        end_of_test;
    end
endmodule : testbench
